// ===== shared/emif_pkg.sv
// constants and types for the external memory strobe timing block
package emif_pkg;

   // ***********************
   // register map
   // ***********************
   localparam logic [7:0] timing_ctrl_addr = 8'h84;
   localparam logic [7:0] config_addr = 8'h85;
   localparam logic [7:0] bank_page_addr = 8'h86;
   localparam logic [7:0] timing_ctrl_reset = 8'hff;
   localparam logic [7:0] config_reset = 8'h00;
   localparam logic [7:0] bank_page_reset = 8'h00;

   // ***********************
   // field layout
   // ***********************
   localparam int setup_hi = 7;
   localparam int setup_lo = 6;
   localparam int width_hi = 5;
   localparam int width_lo = 2;
   localparam int hold_hi = 1;
   localparam int hold_lo = 0;
   localparam int style_bit = 4;
   localparam int mode_hi = 4;
   localparam int mode_lo = 2;
   localparam int latch_hi = 1;
   localparam int latch_lo = 0;

   // ***********************
   // interface modes (config bits 4..2)
   // ***********************
   localparam logic [2:0] mode_mux_a = 3'h1;
   localparam logic [2:0] mode_mux_bank = 3'h2;
   localparam logic [2:0] mode_mux_b = 3'h3;
   localparam logic [2:0] mode_nmux_a = 3'h5;
   localparam logic [2:0] mode_nmux_bank = 3'h6;
   localparam logic [2:0] mode_nmux_b = 3'h7;

   // fixed overhead cycles of an external move
   localparam logic [4:0] move_overhead = 5'h4;

   typedef enum logic [2:0] {
      st_idle = 3'b000,
      st_latch_hi = 3'b001,
      st_latch_lo = 3'b010,
      st_setup = 3'b011,
      st_strobe = 3'b100,
      st_hold = 3'b101,
      st_tail = 3'b110
   } seq_state_t;

endpackage : emif_pkg

// ===== logic/emif_cycle_counter.sv
// down counter that flags the last cycle of a programmed phase
`timescale 1ns/1ps
`default_nettype none

module emif_cycle_counter (
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // control
   input wire logic load,
   input wire logic [4:0] load_value,
   // status
   output logic expired
);

   logic [4:0] count;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         count <= 5'h00;
      end else if (load) begin
         count <= load_value;
      end else if (count != 5'h00) begin
         count <= count - 5'h01;
      end
   end

   always_comb begin
      expired = (count == 5'h00) || (count == 5'h01);
   end

endmodule : emif_cycle_counter

`default_nettype wire

// ===== logic/ext_memory_strobe_timing.sv
// external memory interface sequencer with programmable strobe timing
//
// What this block does
// - the 8-bit timing control register resets to all ones so every setting starts longest.
// - setup field bits 7..6 set address setup cycles, code 10 giving two.
// - setup code 11 gives three cycles and codes step down to zero.
// - strobe width field bits 5..2 sets read and write width, code 0000 giving one cycle.
// - strobe width is field plus one, so 1111 gives sixteen cycles.
// - hold field bits 1..0 keeps the address driven zero to three cycles after the strobe.
// - modes 101, 110, 111 run 16-bit moves non-multiplexed with the full address driven.
// - modes 101 and 111 run 8-bit moves with the upper address byte undriven.
// - mode 110 runs 8-bit moves with the upper byte from the bank page register.
// - modes 001, 010, 011 run 16-bit moves multiplexed, low address shared with data.
// - an 8-bit move takes its low address byte from the indirect pointer value.
// - a non-multiplexed move lasts setup plus strobe plus hold plus four cycles; a multiplexed move adds both latch phases.
// - config bit 4 set gives separate pins, clear gives a shared bus with a latch strobe unless bits 3..2 are also zero.
// - the latch pulse field sets latch high and low widths from one to four cycles.
// - in multiplexed mode the low address shows while latch is high, data after it falls.
`timescale 1ns/1ps
`default_nettype none

module ext_memory_strobe_timing
   import emif_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // core move request
   input wire logic move_start,
   input wire logic move_write,
   input wire logic move_wide,
   input wire logic [15:0] data_pointer_reg,
   input wire logic [7:0] indirect_pointer,
   input wire logic [7:0] move_wdata,
   output logic move_busy,
   output logic move_done,
   output logic [7:0] move_rdata,
   // external address high byte
   output logic [7:0] addr_hi_out,
   output logic addr_hi_oe,
   // external address low byte, non-multiplexed
   output logic [7:0] addr_lo_out,
   output logic addr_lo_oe,
   // external data or shared bus
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   // strobes, read and write active low, address latch active high
   output logic rd_n,
   output logic wr_n,
   output logic addr_latch
);

   // ***********************
   // registers
   // ***********************
   logic [7:0] emif_timing_control;
   logic [7:0] emif_config_reg;
   logic [7:0] bank_page_reg;
   logic [7:0] data_sync1;
   logic [7:0] data_sync2;
   logic [2:0] rd_end;

   function automatic logic [2:0] iface_mode(input logic [7:0] cfg);
      iface_mode = cfg[mode_hi:mode_lo];
   endfunction : iface_mode

   function automatic logic is_muxed(input logic [7:0] cfg);
      logic [2:0] m;
      m = iface_mode(cfg);
      is_muxed = (m == mode_mux_a) || (m == mode_mux_bank) || (m == mode_mux_b);
   endfunction : is_muxed

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         emif_timing_control <= timing_ctrl_reset;
      end else if (reg_write && reg_addr == timing_ctrl_addr) begin
         emif_timing_control <= reg_wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         emif_config_reg <= config_reset;
         bank_page_reg <= bank_page_reset;
      end else if (reg_write && reg_addr == config_addr) begin
         emif_config_reg <= reg_wdata;
      end else if (reg_write && reg_addr == bank_page_addr) begin
         bank_page_reg <= reg_wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         case (reg_addr)
            timing_ctrl_addr: reg_rdata <= emif_timing_control;
            config_addr: reg_rdata <= emif_config_reg;
            bank_page_addr: reg_rdata <= bank_page_reg;
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // pin inputs pass two flops
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         data_sync1 <= 8'h00;
         data_sync2 <= 8'h00;
      end else begin
         data_sync1 <= data_in;
         data_sync2 <= data_sync1;
      end
   end

   // ***********************
   // timing fields
   // ***********************
   // setup field
   logic [4:0] setup_cycles;
   logic [4:0] strobe_cycles;
   logic [4:0] hold_cycles;
   logic [4:0] latch_cycles;
   always_comb begin
      setup_cycles = {3'h0, emif_timing_control[setup_hi:setup_lo]};
      strobe_cycles = {1'h0, emif_timing_control[width_hi:width_lo]} + 5'h01;
      hold_cycles = {3'h0, emif_timing_control[hold_hi:hold_lo]};
      latch_cycles = {3'h0, emif_config_reg[latch_hi:latch_lo]} + 5'h01;
   end

   // ***********************
   // sequencer
   // ***********************
   seq_state_t state;
   seq_state_t next_state;
   logic load;
   logic expired;
   logic muxed;
   logic [4:0] load_value;
   logic req_write;
   logic req_wide;
   logic [15:0] req_addr;
   logic [7:0] req_wdata;

   emif_cycle_counter phase_counter (
      .sys_clk(sys_clk),
      .srst(srst),
      .load(load),
      .load_value(load_value),
      .expired(expired)
   );

   always_comb begin
      next_state = state;
      load_value = 5'h00;
      load = 1'b0;
      case (state)
         st_idle: begin
            if (move_start) begin
               load = 1'b1;
               if (is_muxed(emif_config_reg)) begin
                  next_state = st_latch_hi;
                  load_value = latch_cycles;
               end else begin
                  next_state = (setup_cycles == 5'h00) ? st_strobe : st_setup;
                  load_value = (setup_cycles == 5'h00) ? strobe_cycles : setup_cycles;
               end
            end
         end
         st_latch_hi: begin
            if (expired) begin
               next_state = st_latch_lo;
               load = 1'b1;
               load_value = latch_cycles;
            end
         end
         st_latch_lo: begin
            if (expired) begin
               next_state = (setup_cycles == 5'h00) ? st_strobe : st_setup;
               load = 1'b1;
               load_value = (setup_cycles == 5'h00) ? strobe_cycles : setup_cycles;
            end
         end
         st_setup: begin
            if (expired) begin
               next_state = st_strobe;
               load = 1'b1;
               load_value = strobe_cycles;
            end
         end
         st_strobe: begin
            if (expired) begin
               next_state = (hold_cycles == 5'h00) ? st_tail : st_hold;
               load = 1'b1;
               load_value = (hold_cycles == 5'h00) ? move_overhead - 5'h01 : hold_cycles;
            end
         end
         st_hold: begin
            if (expired) begin
               next_state = st_tail;
               load = 1'b1;
               load_value = move_overhead - 5'h01;
            end
         end
         st_tail: begin
            if (expired) begin
               next_state = st_idle;
            end
         end
         default: next_state = st_idle;
      endcase
   end

   // zero setup or hold codes skip their phase, so address and strobe move together
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state <= st_idle;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         req_write <= 1'b0;
         req_wide <= 1'b0;
         req_addr <= 16'h0000;
         req_wdata <= 8'h00;
         muxed <= 1'b0;
      end else if (state == st_idle && move_start) begin
         req_write <= move_write;
         req_wide <= move_wide;
         req_wdata <= move_wdata;
         muxed <= is_muxed(emif_config_reg);
         req_addr <= move_wide ? data_pointer_reg : {bank_page_reg, indirect_pointer};
      end
   end

   // ***********************
   // pin drive
   // ***********************
   logic active;
   logic hi_drive;
   always_comb begin
      active = (state != st_idle) && (state != st_tail);
      // wide moves drive all 16 bits
      // no bank select leaves high byte free
      hi_drive = active && (req_wide || iface_mode(emif_config_reg) == mode_nmux_bank
                            || iface_mode(emif_config_reg) == mode_mux_bank);
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         addr_hi_out <= 8'h00;
         addr_hi_oe <= 1'b0;
         addr_lo_out <= 8'h00;
         addr_lo_oe <= 1'b0;
      end else begin
         addr_hi_out <= req_addr[15:8];
         addr_hi_oe <= hi_drive;
         addr_lo_out <= req_addr[7:0];
         addr_lo_oe <= active && !muxed;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         data_out <= 8'h00;
         data_oe <= 1'b0;
         addr_latch <= 1'b0;
      end else begin
         // address while latch high, data after
         addr_latch <= state == st_latch_hi;
         if (muxed && state == st_latch_hi) begin
            data_out <= req_addr[7:0];
            data_oe <= 1'b1;
         end else begin
            data_out <= req_wdata;
            data_oe <= req_write && (state == st_setup || state == st_strobe || state == st_hold);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rd_n <= 1'b1;
         wr_n <= 1'b1;
      end else begin
         rd_n <= !(state == st_strobe && !req_write);
         wr_n <= !(state == st_strobe && req_write);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         move_busy <= 1'b0;
         move_done <= 1'b0;
         move_rdata <= 8'h00;
         rd_end <= 3'h0;
      end else begin
         move_busy <= next_state != st_idle;
         move_done <= state == st_tail && expired;
         rd_end <= {rd_end[1:0], state == st_strobe && expired && !req_write};
         // take the bus sample of the last strobe edge once it leaves the synchroniser
         if (rd_end[2]) begin
            move_rdata <= data_sync2;
         end
      end
   end

endmodule : ext_memory_strobe_timing

`default_nettype wire

// ===== sim/ext_memory_strobe_timing_sva.sv
// checker for the external memory strobe timing block
`timescale 1ns/1ps
`default_nettype none
module emif_checker
   import emif_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   // move and pins
   input wire logic move_busy,
   input wire logic move_done,
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic addr_latch
);
   logic [7:0] tc;
   logic [4:0] low_cnt;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   // shadow of the timing register
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         tc <= timing_ctrl_reset;
      end else if (reg_write && reg_addr == timing_ctrl_addr) begin
         tc <= reg_wdata;
      end
   end
   // length of the current strobe
   always_ff @(posedge sys_clk) begin
      if (srst || (rd_n && wr_n)) begin
         low_cnt <= 5'h00;
      end else begin
         low_cnt <= low_cnt + 5'h01;
      end
   end
   a_timing_readback: assert property (reg_read && reg_addr == timing_ctrl_addr |=>
      reg_rdata == tc) else $error("timing register read wrong");
   a_rdata_idle_zero: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside read");
   a_strobe_width: assert property ($rose(rd_n && wr_n) |->
      low_cnt == tc[5:2] + 5'h01) else $error("strobe width wrong");
   a_strobes_apart: assert property (!(!rd_n && !wr_n))
      else $error("both strobes low");
   a_strobe_in_move: assert property (!rd_n || !wr_n |-> move_busy)
      else $error("strobe outside move");
   a_idle_quiet: assert property (!move_busy && !move_done |->
      rd_n && wr_n && !addr_latch) else $error("activity while idle");
   a_done_pulse: assert property (move_done |=> !move_done)
      else $error("done longer than one cycle");
   a_write_data_held: assert property (!wr_n |-> data_oe && ($fell(wr_n) || $stable(data_out)))
      else $error("write data not held");
   a_read_bus_free: assert property (!rd_n |-> !data_oe)
      else $error("bus driven during read");
   a_latch_shows_addr: assert property (addr_latch |-> data_oe)
      else $error("shared bus not driven while latch high");
   c_read: cover property ($fell(rd_n));
   c_write: cover property ($fell(wr_n));
   c_latch: cover property ($fell(addr_latch));
   c_done: cover property (move_done);
endmodule : emif_checker
bind ext_memory_strobe_timing emif_checker emif_checker_i (.sys_clk, .srst, .reg_addr,
   .reg_wdata, .reg_write, .reg_read, .reg_rdata, .move_busy, .move_done, .data_out,
   .data_oe, .rd_n, .wr_n, .addr_latch);
`default_nettype wire

// ===== sim/ext_sram_model.sv
// asynchronous memory with address latch on the far side of the interface
`timescale 1ns/1ps
`default_nettype none
module ext_sram_model (
   // clock and mode
   input wire logic sys_clk,
   input wire logic mux,
   // pins from the interface
   input wire logic [7:0] addr_hi_out,
   input wire logic addr_hi_oe,
   input wire logic [7:0] addr_lo_out,
   input wire logic [7:0] data_out,
   input wire logic addr_latch,
   input wire logic rd_n,
   input wire logic wr_n,
   // read data back
   output logic [7:0] data_in
);
   logic [7:0] mem [0:65535];
   logic [7:0] lat;
   logic [7:0] last = 8'h00;
   logic [15:0] a;
   // external latch, transparent while strobe high
   always_latch begin
      if (addr_latch) begin
         lat <= data_out;
      end
   end
   assign a = {addr_hi_oe ? addr_hi_out : 8'h00, mux ? lat : addr_lo_out};
   always @(posedge sys_clk) begin
      if (!wr_n) begin
         mem[a] <= data_out;
      end
      if (!rd_n) begin
         last <= mem[a];
      end
   end
   // data valid while read strobe low, scrambled after
   assign data_in = !rd_n ? mem[a] : ~last;
endmodule : ext_sram_model
`default_nettype wire

// ===== sim/tb.sv
// self-checking testbench for the external memory strobe timing block
`timescale 1ns/1ps
`default_nettype none
module tb
   import emif_pkg::*;
;
   logic sys_clk = 1'b0, srst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, move_start = 1'b0;
   logic move_write = 1'b0, move_wide = 1'b0, mux = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, indirect_pointer = 8'h00, move_wdata = 8'h00;
   logic [15:0] data_pointer_reg = 16'h0000;
   logic [7:0] reg_rdata, move_rdata, addr_hi_out, addr_lo_out, data_in, data_out, a_hi, a_lo, lat;
   logic move_busy, move_done, addr_hi_oe, addr_lo_oe, data_oe, rd_n, wr_n, addr_latch, hi_oe;
   int n_mismatch = 0, num_checks = 0, n_set, n_str, n_hold, n_ale, n_cyc, i;
   logic [7:0] cfg_m [3] = '{8'h06, 8'h0f, 8'h08};
   always #20 sys_clk = ~sys_clk;
   ext_memory_strobe_timing ext_memory_strobe_timing_i (.sys_clk, .srst, .reg_addr, .reg_wdata,
      .reg_write, .reg_read, .reg_rdata, .move_start, .move_write, .move_wide, .data_pointer_reg,
      .indirect_pointer, .move_wdata, .move_busy, .move_done, .move_rdata, .addr_hi_out,
      .addr_hi_oe, .addr_lo_out, .addr_lo_oe, .data_in, .data_out, .data_oe, .rd_n, .wr_n,
      .addr_latch);
   ext_sram_model ext_sram_model_i (.sys_clk, .mux, .addr_hi_out, .addr_hi_oe, .addr_lo_out,
      .data_out, .addr_latch, .rd_n, .wr_n, .data_in);
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_write <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge sys_clk);
      reg_write <= 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_read <= 1'b1; reg_addr <= a;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask : reg_rd
   task automatic move(input logic w, input logic wide, input logic [15:0] dp, input logic [7:0] d);
      @(posedge sys_clk);
      move_start <= 1'b1; move_write <= w; move_wide <= wide;
      data_pointer_reg <= dp; indirect_pointer <= dp[7:0]; move_wdata <= d;
      n_set = 0; n_str = 0; n_hold = 0; n_ale = 0;
      @(posedge sys_clk);
      move_start <= 1'b0;
      for (int k = 0; k < 100; k++) begin
         #1;
         n_cyc = k + 1;
         if (addr_latch) begin n_ale++; lat = data_out; end
         if (!rd_n || !wr_n) begin
            n_str++; a_hi = addr_hi_out; hi_oe = addr_hi_oe; a_lo = addr_lo_out;
         end else if (addr_lo_oe) begin
            if (n_str == 0) n_set++; else n_hold++;
         end
         if (move_done) break;
         @(posedge sys_clk);
      end
      chk(move_done, 1'b1);
   endtask : move
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_mismatch++;
      stop_test();
   end
   initial begin
      repeat (8) @(posedge sys_clk);
      srst <= 1'b0;
      reg_rd(timing_ctrl_addr, 8'hff);
      reg_rd(config_addr, config_reset);
      reg_wr(8'h90, 8'h55);
      reg_rd(8'h90, 8'h00);
      reg_wr(bank_page_addr, 8'ha5);
      reg_rd(bank_page_addr, 8'ha5);
      $display("test registers done");
      reg_wr(config_addr, 8'h14);
      for (i = 0; i < 4; i++) begin
         reg_wr(timing_ctrl_addr, {i[1:0], 4'(i * 5), i[1:0]});
         move(1'b1, 1'b1, 16'h1230 + 16'(i), 8'h40 + 8'(i));
         chk(16'(n_set), 16'(i));
         chk(16'(n_str), 16'(i * 5 + 1));
         chk(16'(n_hold), 16'(i));
         chk(16'(n_cyc), 16'(2 * i + i * 5 + 1) + 16'(move_overhead));
         chk({a_hi, a_lo}, 16'h1230 + 16'(i));
      end
      reg_wr(timing_ctrl_addr, 8'h0c);
      move(1'b0, 1'b1, 16'h1232, 8'h00);
      chk(move_rdata, 8'h42);
      $display("test timing done");
      move(1'b1, 1'b0, 16'h0077, 8'h01);
      chk(hi_oe, 1'b0);
      chk(a_lo, 8'h77);
      reg_wr(config_addr, 8'h18);
      move(1'b1, 1'b0, 16'h0033, 8'h02);
      chk({hi_oe, a_hi}, {1'b1, 8'ha5});
      reg_wr(config_addr, 8'h1c);
      move(1'b1, 1'b0, 16'h0034, 8'h03);
      chk(hi_oe, 1'b0);
      $display("test modes done");
      mux <= 1'b1;
      for (i = 0; i < 3; i++) begin
         reg_wr(config_addr, cfg_m[i]);
         move(1'b1, 1'b1, 16'hbe12 + 16'(i), 8'h60 + 8'(i));
         chk(16'(n_ale), 16'(cfg_m[i][1:0]) + 16'h1);
         chk({a_hi, lat}, 16'hbe12 + 16'(i));
         chk(16'(n_cyc), 16'(2 * cfg_m[i][1:0] + 6) + 16'(move_overhead));
      end
      move(1'b0, 1'b1, 16'hbe13, 8'h00);
      chk(move_rdata, 8'h61);
      reg_wr(timing_ctrl_addr, 8'h00);
      move(1'b0, 1'b1, 16'hbe14, 8'h00);
      chk(move_rdata, 8'h62);
      chk(16'(n_str), 16'h1);
      chk(16'(n_cyc), 16'h3 + 16'(move_overhead));
      $display("test multiplexed done");
      stop_test();
   end
endmodule : tb
`default_nettype wire
